// File: dsp_cfg_pkg.sv
// Package: register map, field layout and decoded configuration of DSP bank
package dsp_cfg_pkg;

   typedef logic [8:0] dsp_word_t;
   typedef logic [5:0] dsp_index_t;

   // Bus and bank geometry
   localparam int ADR_W = 8;
   localparam int NUM_PLAIN = 12;
   localparam int NUM_NOTCH = 4;
   localparam int NOTCH_COMMIT_BIT = 8;

   // Register indices (byte address is four times the index)
   localparam dsp_index_t OFS_EQ_BAND5 = 6'h16;
   localparam dsp_index_t OFS_LIM1 = 6'h18;
   localparam dsp_index_t OFS_LIM2 = 6'h19;
   localparam dsp_index_t OFS_NOTCH_A0_HIGH = 6'h1B;
   localparam dsp_index_t OFS_NOTCH_A0_LOW = 6'h1C;
   localparam dsp_index_t OFS_NOTCH_A1_HIGH = 6'h1D;
   localparam dsp_index_t OFS_NOTCH_A1_LOW = 6'h1E;
   localparam dsp_index_t OFS_LVL1 = 6'h20;
   localparam dsp_index_t OFS_LVL2 = 6'h21;
   localparam dsp_index_t OFS_LVL3 = 6'h22;
   localparam dsp_index_t OFS_GATE = 6'h23;
   localparam dsp_index_t OFS_PLL_INT = 6'h24;
   localparam dsp_index_t OFS_PLL_FRAC_HIGH = 6'h25;
   localparam dsp_index_t OFS_PLL_FRAC_MID = 6'h26;
   localparam dsp_index_t OFS_PLL_FRAC_LOW = 6'h27;
   localparam dsp_index_t OFS_WIDEN = 6'h29;

   // Slot numbers of the plain registers
   localparam int SLOT_EQ5 = 0;
   localparam int SLOT_LIM1 = 1;
   localparam int SLOT_LIM2 = 2;
   localparam int SLOT_LVL1 = 3;
   localparam int SLOT_LVL2 = 4;
   localparam int SLOT_LVL3 = 5;
   localparam int SLOT_GATE = 6;
   localparam int SLOT_PLL_INT = 7;
   localparam int SLOT_FRAC_HIGH = 8;
   localparam int SLOT_FRAC_MID = 9;
   localparam int SLOT_FRAC_LOW = 10;
   localparam int SLOT_WIDEN = 11;

   // Plain register table: index, reset value, implemented bits
   localparam dsp_index_t PLAIN_OFS [NUM_PLAIN] = '{
      OFS_EQ_BAND5, OFS_LIM1, OFS_LIM2, OFS_LVL1, OFS_LVL2, OFS_LVL3,
      OFS_GATE, OFS_PLL_INT, OFS_PLL_FRAC_HIGH, OFS_PLL_FRAC_MID,
      OFS_PLL_FRAC_LOW, OFS_WIDEN};
   localparam dsp_word_t PLAIN_RST [NUM_PLAIN] = '{
      9'h02C, 9'h032, 9'h000, 9'h038, 9'h00B, 9'h032,
      9'h000, 9'h008, 9'h00C, 9'h093, 9'h0E9, 9'h000};
   localparam dsp_word_t PLAIN_MASK [NUM_PLAIN] = '{
      9'h07F, 9'h1FF, 9'h07F, 9'h1BF, 9'h0FF, 9'h1FF,
      9'h00F, 9'h01F, 9'h03F, 9'h1FF, 9'h1FF, 9'h00F};

   // Notch table; commit bit is write-only and never stored
   localparam dsp_index_t NOTCH_OFS [NUM_NOTCH] = '{
      OFS_NOTCH_A0_HIGH, OFS_NOTCH_A0_LOW, OFS_NOTCH_A1_HIGH,
      OFS_NOTCH_A1_LOW};
   localparam dsp_word_t NOTCH_RST = 9'h000;
   localparam dsp_word_t NOTCH_MASK [NUM_NOTCH] = '{
      9'h0FF, 9'h07F, 9'h07F, 9'h07F};

   // Field positions
   localparam int EQ5_CORNER_LSB = 5;
   localparam int EQ5_GAIN_LSB = 0;
   localparam int LIM_ON_BIT = 8;
   localparam int LIM_RELEASE_LSB = 4;
   localparam int LIM_ATTACK_LSB = 0;
   localparam int LIM_THRESH_LSB = 4;
   localparam int LIM_BOOST_LSB = 0;
   localparam int NOTCH_ON_BIT = 7;
   localparam int NOTCH_HALF_W = 7;
   localparam int LVL_LEFT_BIT = 8;
   localparam int LVL_RIGHT_BIT = 7;
   localparam int LVL_CEIL_LSB = 3;
   localparam int LVL_FLOOR_LSB = 0;
   localparam int LVL_HOLD_LSB = 4;
   localparam int LVL_TARGET_LSB = 0;
   localparam int LVL_MODE_BIT = 8;
   localparam int LVL_RELEASE_LSB = 4;
   localparam int LVL_ATTACK_LSB = 0;
   localparam int GATE_ON_BIT = 3;
   localparam int GATE_THRESH_LSB = 0;
   localparam int PLL_HALVE_BIT = 4;
   localparam int PLL_INT_LSB = 0;
   localparam int FRAC_HIGH_W = 6;
   localparam int WIDEN_LSB = 0;

   // Code limits; codes above a limit act as the limit
   localparam logic [4:0] EQ_GAIN_MAX = 5'h18;
   localparam logic [3:0] LIM_ATTACK_MAX = 4'hB;
   localparam logic [2:0] LIM_THRESH_MAX = 3'h5;
   localparam logic [3:0] LIM_BOOST_MAX = 4'hC;
   localparam logic [3:0] LVL_HOLD_MAX = 4'hA;
   localparam logic [3:0] LVL_ATTACK_MAX = 4'hA;

   // Level-control step timing
   localparam int LVL_RELEASE_BASE_US = 500;
   localparam int LVL_ATTACK_BASE_US = 125;
   localparam int LVL_LIMITER_SHIFT = 2;
   localparam int LVL_HOLD_BASE_MS = 2;
   localparam int LVL_HOLD_CAP_MS = 1000;

   // Decoded configuration handed to the signal-processing datapaths
   typedef struct packed {
      logic [1:0] bandFiveCornerSel;
      logic [4:0] bandFiveGain;
      logic playbackLimiterOn;
      logic [3:0] playbackLimiterRelease;
      logic [3:0] playbackLimiterAttack;
      logic [2:0] playbackLimiterThreshold;
      logic [3:0] playbackLimiterBoost;
      logic [3:0] playbackFixedBoost;
      logic notchOn;
      logic [13:0] notchCoefZero;
      logic [13:0] notchCoefOne;
      logic levelCtrlLeftOn;
      logic levelCtrlRightOn;
      logic [2:0] levelCtrlGainCeiling;
      logic [2:0] levelCtrlGainFloor;
      logic [9:0] levelCtrlHoldMs;
      logic [3:0] levelCtrlTarget;
      logic levelCtrlLimiterSel;
      logic [23:0] levelCtrlReleaseStepUs;
      logic [17:0] levelCtrlAttackStepUs;
      logic gateOn;
      logic [2:0] gateThreshold;
      logic pllInputHalve;
      logic [3:0] pllIntegerRatio;
      logic [23:0] pllFractionRatio;
      logic [3:0] stereoWidenDepth;
      logic stereoWidenOn;
   } dsp_cfg_s;

endpackage : dsp_cfg_pkg

// File: dsp_config_registers.sv
// Module: audio DSP configuration register bank on a classic Wishbone slave
// Functional notes
// - Band-five corner: 2-bit code, default second
// - Band-five gain 1dB steps, reserved codes above
// - Playback limiter enable bit, off at reset
// - Limiter release 4-bit doubling code, default 0011
// - Limiter attack doubling, saturates from 1011
// - Limiter threshold 1dB steps, saturates from 101
// - Boost 0..12dB; fixed gain when limiter off
// - Notch writes pend until commit bit set
// - Notch enable beside first coefficient, off reset
// - Notch coefficients from high and low halves
// - Level-control channel enables: bit left, bit right
// - Level-control gain ceiling and floor limits
// - Hold time doubles from 2ms, caps 1000ms
// - Level target 1.5dB steps, default code 1011
// - Mode bit: normal regulation or limiter
// - Release step doubling, 500us or 125us base
// - Attack step doubling, saturates from 1010
// - Noise gate enable and 3-bit threshold
// - PLL input prescaler halves or passes clock
// - Fraction ratio from three registers, 24 bits
// - Stereo widening depth, zero disables effect
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/10ps

module dsp_config_registers (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [dsp_cfg_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Decoded configuration to the datapaths
   output dsp_cfg_pkg::dsp_cfg_s cfg
);
   import dsp_cfg_pkg::*;

   // Clamp a code to its highest legal value
   function automatic logic [4:0] clampCode(input logic [4:0] code,
                                            input logic [4:0] limit);
      clampCode = (code > limit) ? limit : code;
   endfunction : clampCode

   // Byte-lane merge: lane 0 covers bits 7..0, lane 1 covers bit 8
   function automatic dsp_word_t laneMerge(input dsp_word_t old,
                                           input dsp_word_t wr,
                                           input logic [3:0] sel);
      dsp_word_t laneMask;
      laneMask = {sel[1], {8{sel[0]}}};
      laneMerge = (old & ~laneMask) | (wr & laneMask);
   endfunction : laneMerge

   dsp_index_t regIndex;
   logic request;
   logic writeTaken;
   logic commitReq;
   dsp_word_t wrWord;
   dsp_word_t plainReg [NUM_PLAIN];
   dsp_word_t notchPend [NUM_NOTCH];
   dsp_word_t notchLive [NUM_NOTCH];
   logic [NUM_PLAIN-1:0] plainHit;
   logic [NUM_NOTCH-1:0] notchHit;
   dsp_word_t readWord;
   dsp_cfg_s next_cfg;

   // Address decode; low address bits are ignored as words are aligned
   assign regIndex = wb_adr_i[ADR_W-1:2];
   assign request = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign writeTaken = request & wb_we_i;
   assign wrWord = wb_dat_i[8:0];
   // Commit only counts when the lane holding bit 8 is written
   assign commitReq = wrWord[NOTCH_COMMIT_BIT] & wb_sel_i[1];

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= request;
      end
   end

   // Plain registers, one generated slot each
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PLAIN; gi++) begin : g_plain
         assign plainHit[gi] = (regIndex == PLAIN_OFS[gi]);
         always_ff @(posedge clk_sys) begin
            if (reset) begin
               plainReg[gi] <= PLAIN_RST[gi];
            end else if (writeTaken && plainHit[gi]) begin
               // Unimplemented bits stay zero
               plainReg[gi] <= laneMerge(plainReg[gi], wrWord, wb_sel_i)
                               & PLAIN_MASK[gi];
            end
         end
      end
   endgenerate

   // Notch double buffer: pending copy always tracks writes,
   // live copy only moves on a commit so all four change together
   generate
      for (gi = 0; gi < NUM_NOTCH; gi++) begin : g_notch
         assign notchHit[gi] = (regIndex == NOTCH_OFS[gi]);
         always_ff @(posedge clk_sys) begin
            if (reset) begin
               notchPend[gi] <= NOTCH_RST;
               notchLive[gi] <= NOTCH_RST;
            end else if (writeTaken && notchHit[gi]) begin
               notchPend[gi] <= laneMerge(notchPend[gi], wrWord,
                                          wb_sel_i) & NOTCH_MASK[gi];
               if (commitReq) begin
                  notchLive[gi] <= laneMerge(notchPend[gi], wrWord,
                                             wb_sel_i) & NOTCH_MASK[gi];
               end
            end else if (writeTaken && commitReq && (|notchHit)) begin
               notchLive[gi] <= notchPend[gi];
            end
         end
      end
   endgenerate

   // Read mux; live notch values are shown, unmapped reads as zero
   always_comb begin
      readWord = '0;
      for (int i = 0; i < NUM_PLAIN; i++) begin
         if (plainHit[i]) begin
            readWord = plainReg[i];
         end
      end
      for (int i = 0; i < NUM_NOTCH; i++) begin
         if (notchHit[i]) begin
            readWord = notchLive[i];
         end
      end
   end

   // Read data registered with the ack
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wb_dat_o <= '0;
      end else if (request && !wb_we_i) begin
         wb_dat_o <= {23'h000000, readWord};
      end
   end

   // Decode register fields into datapath settings
   always_comb begin
      dsp_word_t eq5;
      dsp_word_t lim1;
      dsp_word_t lim2;
      dsp_word_t lvl1;
      dsp_word_t lvl2;
      dsp_word_t lvl3;
      dsp_word_t gate;
      dsp_word_t pllInt;
      logic [3:0] holdCode;
      logic [3:0] relCode;
      logic [3:0] atkCode;
      logic [23:0] relUs;
      logic [17:0] atkUs;
      holdCode = '0;
      relCode = '0;
      atkCode = '0;
      relUs = '0;
      atkUs = '0;
      eq5 = plainReg[SLOT_EQ5];
      lim1 = plainReg[SLOT_LIM1];
      lim2 = plainReg[SLOT_LIM2];
      lvl1 = plainReg[SLOT_LVL1];
      lvl2 = plainReg[SLOT_LVL2];
      lvl3 = plainReg[SLOT_LVL3];
      gate = plainReg[SLOT_GATE];
      pllInt = plainReg[SLOT_PLL_INT];
      next_cfg = '0;

      // Band-five equaliser
      next_cfg.bandFiveCornerSel = eq5[EQ5_CORNER_LSB +: 2];
      // Reserved gain codes act as the highest gain
      next_cfg.bandFiveGain =
         clampCode(eq5[EQ5_GAIN_LSB +: 5], EQ_GAIN_MAX);

      // Playback limiter
      next_cfg.playbackLimiterOn = lim1[LIM_ON_BIT];
      next_cfg.playbackLimiterRelease = lim1[LIM_RELEASE_LSB +: 4];
      next_cfg.playbackLimiterAttack = 4'(clampCode(
         {1'b0, lim1[LIM_ATTACK_LSB +: 4]}, {1'b0, LIM_ATTACK_MAX}));
      next_cfg.playbackLimiterThreshold = 3'(clampCode(
         {2'b00, lim2[LIM_THRESH_LSB +: 3]},
         {2'b00, LIM_THRESH_MAX}));
      // Boost is the limiter's ceiling when on, a fixed gain when off
      if (lim1[LIM_ON_BIT]) begin
         next_cfg.playbackLimiterBoost = 4'(clampCode(
            {1'b0, lim2[LIM_BOOST_LSB +: 4]}, {1'b0, LIM_BOOST_MAX}));
      end else begin
         next_cfg.playbackFixedBoost = 4'(clampCode(
            {1'b0, lim2[LIM_BOOST_LSB +: 4]}, {1'b0, LIM_BOOST_MAX}));
      end

      // Notch filter from the live copy only
      next_cfg.notchOn = notchLive[0][NOTCH_ON_BIT];
      next_cfg.notchCoefZero = {notchLive[0][NOTCH_HALF_W-1:0],
                                notchLive[1][NOTCH_HALF_W-1:0]};
      next_cfg.notchCoefOne = {notchLive[2][NOTCH_HALF_W-1:0],
                               notchLive[3][NOTCH_HALF_W-1:0]};

      // Record-path level control
      next_cfg.levelCtrlLeftOn = lvl1[LVL_LEFT_BIT];
      next_cfg.levelCtrlRightOn = lvl1[LVL_RIGHT_BIT];
      next_cfg.levelCtrlGainCeiling = lvl1[LVL_CEIL_LSB +: 3];
      next_cfg.levelCtrlGainFloor = lvl1[LVL_FLOOR_LSB +: 3];
      holdCode = 4'(clampCode({1'b0, lvl2[LVL_HOLD_LSB +: 4]},
                              {1'b0, LVL_HOLD_MAX}));
      // Top code would give 1024ms; the hold stops at its cap instead
      if (holdCode == 4'h0) begin
         next_cfg.levelCtrlHoldMs = 10'h000;
      end else if (holdCode == LVL_HOLD_MAX) begin
         next_cfg.levelCtrlHoldMs = 10'(LVL_HOLD_CAP_MS);
      end else begin
         next_cfg.levelCtrlHoldMs =
            10'(LVL_HOLD_BASE_MS) << (holdCode - 4'h1);
      end
      next_cfg.levelCtrlTarget = lvl2[LVL_TARGET_LSB +: 4];
      next_cfg.levelCtrlLimiterSel = lvl3[LVL_MODE_BIT];

      // Step durations; limiter mode runs four times faster
      relCode = lvl3[LVL_RELEASE_LSB +: 4];
      atkCode = 4'(clampCode({1'b0, lvl3[LVL_ATTACK_LSB +: 4]},
                             {1'b0, LVL_ATTACK_MAX}));
      relUs = 24'(LVL_RELEASE_BASE_US) << relCode;
      atkUs = 18'(LVL_ATTACK_BASE_US) << atkCode;
      if (lvl3[LVL_MODE_BIT]) begin
         relUs = relUs >> LVL_LIMITER_SHIFT;
         atkUs = atkUs >> LVL_LIMITER_SHIFT;
      end
      next_cfg.levelCtrlReleaseStepUs = relUs;
      next_cfg.levelCtrlAttackStepUs = atkUs;

      // Noise gate
      next_cfg.gateOn = gate[GATE_ON_BIT];
      next_cfg.gateThreshold = gate[GATE_THRESH_LSB +: 3];

      // PLL; the integer range is software's duty and passes unchecked
      next_cfg.pllInputHalve = pllInt[PLL_HALVE_BIT];
      next_cfg.pllIntegerRatio = pllInt[PLL_INT_LSB +: 4];
      next_cfg.pllFractionRatio = {
         plainReg[SLOT_FRAC_HIGH][FRAC_HIGH_W-1:0],
         plainReg[SLOT_FRAC_MID],
         plainReg[SLOT_FRAC_LOW]};

      // Stereo widening
      next_cfg.stereoWidenDepth = plainReg[SLOT_WIDEN][WIDEN_LSB +: 4];
      next_cfg.stereoWidenOn =
         |plainReg[SLOT_WIDEN][WIDEN_LSB +: 4];
   end

   // Outputs held in flip-flops so datapaths see glitch-free settings
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cfg <= '0;
      end else begin
         cfg <= next_cfg;
      end
   end

endmodule : dsp_config_registers

// File: dsp_config_registers_checker.sv
// Checker: bus handshake and decoded configuration of the DSP bank
`timescale 1ns/10ps

module dsp_config_registers_checker
   import dsp_cfg_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [dsp_cfg_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Decoded configuration
   input wire dsp_cfg_pkg::dsp_cfg_s cfg
);
   // Request taken by the slave at this edge
   logic req;
   logic notchPend;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign notchPend = req && wb_we_i && !wb_dat_i[8] &&
      wb_adr_i[7:2] >= OFS_NOTCH_A0_HIGH && wb_adr_i[7:2] <= OFS_NOTCH_A1_LOW;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   // Handshake: one answer per request, one cycle long
   property p_ack_resp; req |=> wb_ack_o; endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("no ack");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
   property p_dat_hi; wb_ack_o |-> wb_dat_o[31:9] == 23'h0; endproperty
   a_dat_hi: assert property (p_dat_hi) else $error("upper bits");
   // Reserved codes never reach the datapaths; the unused boost field stays zero and widen enable follows depth
   property p_gain; cfg.bandFiveGain <= 5'h18; endproperty
   a_gain: assert property (p_gain) else $error("gain clamp");
   property p_atk; cfg.playbackLimiterAttack <= 4'hB; endproperty
   a_atk: assert property (p_atk) else $error("attack clamp");
   property p_thr; cfg.playbackLimiterThreshold <= 3'h5; endproperty
   a_thr: assert property (p_thr) else $error("threshold clamp");
   property p_boost; (cfg.playbackLimiterOn ? cfg.playbackFixedBoost :
      cfg.playbackLimiterBoost) == 4'h0; endproperty
   a_boost: assert property (p_boost) else $error("boost route");
   property p_hold; cfg.levelCtrlHoldMs <= 10'd1000; endproperty
   a_hold: assert property (p_hold) else $error("hold cap");
   property p_widen; cfg.stereoWidenOn == (cfg.stereoWidenDepth != 4'h0);
   endproperty
   a_widen: assert property (p_widen) else $error("widen enable");
   // Written depth is seen two edges after the request edge
   property p_widen_wr; req && wb_we_i && wb_sel_i[0] &&
      wb_adr_i[7:2] == OFS_WIDEN |-> ##2 cfg.stereoWidenDepth ==
      $past(wb_dat_i[3:0], 2); endproperty
   a_widen_wr: assert property (p_widen_wr) else $error("depth write");
   // Pending notch writes leave live coefficients alone
   // Compare the settings from before and after the pending write
   property p_notch; notchPend |-> ##2 $stable(cfg.notchCoefZero) &&
      $stable(cfg.notchCoefOne) && $stable(cfg.notchOn); endproperty
   a_notch: assert property (p_notch) else $error("notch early");
endmodule : dsp_config_registers_checker

bind dsp_config_registers dsp_config_registers_checker
   dsp_config_registers_checker_i (.clk_sys(clk_sys), .reset(reset),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cfg(cfg));

// File: dsp_config_registers_tb.sv
// Testbench: register bank reached over classic Wishbone
`timescale 1ns/10ps

module dsp_config_registers_tb;
   import dsp_cfg_pkg::*;
   logic clk_sys = 1'h0;
   logic reset = 1'h1;
   logic wbCyc = 1'h0;
   logic wbStb = 1'h0;
   logic wbWe = 1'h0;
   logic [7:0] wbAdr = 8'h00;
   logic [31:0] wbDatI = 32'h0;
   logic [3:0] wbSel = 4'h0;
   logic [31:0] wbDatO;
   logic wbAck;
   dsp_cfg_s cfg;
   int errorCnt = 0;
   int checkCount = 0;
   dsp_index_t unm [5] = '{6'h17, 6'h1A, 6'h1F, 6'h28, 6'h2A};
   logic [3:0] hc [5] = '{4'h0, 4'h1, 4'h9, 4'hA, 4'hF};
   int he [5] = '{0, 2, 512, 1000, 1000};

   dsp_config_registers dsp_config_registers_i (.clk_sys(clk_sys),
      .reset(reset), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_dat_i(wbDatI), .wb_sel_i(wbSel),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .cfg(cfg));

   // 20 MHz system clock
   always #25 clk_sys = ~clk_sys;

   task automatic printVerdict();
      $display("errors %0d checks %0d", errorCnt, checkCount);
      if (errorCnt == 0 && checkCount > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : printVerdict

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         errorCnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // One classic cycle; ends one idle cycle later with cfg settled
   task automatic wbXfer(input logic we, input dsp_index_t idx,
      input dsp_word_t dat, input logic [3:0] sel, output dsp_word_t rd);
      int n;
      @(posedge clk_sys);
      wbCyc <= 1'h1;
      wbStb <= 1'h1;
      wbWe <= we;
      wbAdr <= {idx, 2'h0};
      wbDatI <= {23'h0, dat};
      wbSel <= sel;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wbAck !== 1'h1 && n < 20);
      rd = wbDatO[8:0];
      // A missing ack counts once; the run still reaches the verdict
      if (wbAck !== 1'h1) check("ack", {31'h0, wbAck}, 32'h1);
      wbCyc <= 1'h0;
      wbStb <= 1'h0;
      @(posedge clk_sys);
      #1;
   endtask : wbXfer

   task automatic wr(input dsp_index_t idx, input dsp_word_t dat);
      dsp_word_t d;
      wbXfer(1'h1, idx, dat, 4'h3, d);
   endtask : wr

   task automatic rdChk(input dsp_index_t idx, input dsp_word_t exp);
      dsp_word_t d;
      wbXfer(1'h0, idx, 9'h000, 4'h3, d);
      check($sformatf("reg %h", idx), d, exp);
   endtask : rdChk

   // Main sequence
   initial begin
      dsp_word_t d;
      repeat (2) @(posedge clk_sys);
      reset <= 1'h0;
      @(posedge clk_sys);
      #1;
      // Defaults after reset
      for (int i = 0; i < NUM_PLAIN; i++) begin
         rdChk(PLAIN_OFS[i], PLAIN_RST[i]);
      end
      for (int i = 0; i < NUM_NOTCH; i++) rdChk(NOTCH_OFS[i], 9'h000);
      check("corner", cfg.bandFiveCornerSel, 1);
      check("limon", cfg.playbackLimiterOn, 0);
      check("limrel", cfg.playbackLimiterRelease, 3);
      check("limatk", cfg.playbackLimiterAttack, 2);
      check("lvlon", {cfg.levelCtrlLeftOn, cfg.levelCtrlRightOn}, 0);
      check("ceil", cfg.levelCtrlGainCeiling, 7);
      check("floor", cfg.levelCtrlGainFloor, 0);
      check("target", cfg.levelCtrlTarget, 11);
      check("mode", cfg.levelCtrlLimiterSel, 0);
      check("relus", cfg.levelCtrlReleaseStepUs, 4000);
      check("atkus", cfg.levelCtrlAttackStepUs, 500);
      check("gate", cfg.gateOn, 0);
      check("halve", cfg.pllInputHalve, 0);
      check("pllint", cfg.pllIntegerRatio, 8);
      check("frac", cfg.pllFractionRatio, {6'h0C, 9'h093, 9'h0E9});
      check("widen", cfg.stereoWidenOn, 0);
      // Implemented bits, unmapped places, byte lanes
      for (int i = 0; i < NUM_PLAIN; i++) begin
         wr(PLAIN_OFS[i], 9'h1FF);
         rdChk(PLAIN_OFS[i], PLAIN_MASK[i]);
      end
      for (int i = 0; i < 5; i++) begin
         wr(unm[i], 9'h1FF);
         rdChk(unm[i], 9'h000);
      end
      rdChk(OFS_EQ_BAND5, 9'h07F);
      wbXfer(1'h1, OFS_LIM1, 9'h000, 4'h1, d);
      rdChk(OFS_LIM1, 9'h100);
      // Band five codes and reserved gain
      for (int c = 0; c < 4; c++) begin
         wr(OFS_EQ_BAND5, {1'h0, 2'(c), 5'(c * 8)});
         check("corner", cfg.bandFiveCornerSel, c);
         check("gain", cfg.bandFiveGain, c * 8);
      end
      wr(OFS_EQ_BAND5, 9'h019);
      check("gain", cfg.bandFiveGain, 24);
      rdChk(OFS_EQ_BAND5, 9'h019);
      // Playback limiter fields and boost routing
      wr(OFS_LIM1, 9'h0AF);
      check("limrel", cfg.playbackLimiterRelease, 10);
      check("limatk", cfg.playbackLimiterAttack, 11);
      wr(OFS_LIM2, 9'h07F);
      check("thr", cfg.playbackLimiterThreshold, 5);
      check("fixb", cfg.playbackFixedBoost, 12);
      wr(OFS_LIM1, 9'h10A);
      check("limon", cfg.playbackLimiterOn, 1);
      check("limatk", cfg.playbackLimiterAttack, 10);
      check("limb", cfg.playbackLimiterBoost, 12);
      // Level control enables, limits, hold and step timing
      for (int k = 0; k < 4; k++) begin
         wr(OFS_LVL1, {2'(k), 1'h0, 3'h5, 3'h2});
         check("lvlon", {cfg.levelCtrlLeftOn, cfg.levelCtrlRightOn}, k);
      end
      check("ceil", cfg.levelCtrlGainCeiling, 5);
      check("floor", cfg.levelCtrlGainFloor, 2);
      for (int i = 0; i < 5; i++) begin
         wr(OFS_LVL2, {1'h0, hc[i], 4'h0});
         check("hold", cfg.levelCtrlHoldMs, he[i]);
      end
      check("target", cfg.levelCtrlTarget, 0);
      wr(OFS_LVL3, 9'h100);
      check("mode", cfg.levelCtrlLimiterSel, 1);
      check("relus", cfg.levelCtrlReleaseStepUs, 125);
      check("atkus", cfg.levelCtrlAttackStepUs, 31);
      wr(OFS_LVL3, 9'h12F);
      check("atkus", cfg.levelCtrlAttackStepUs, 32000);
      wr(OFS_LVL3, 9'h0AF);
      check("relus", cfg.levelCtrlReleaseStepUs, 512000);
      check("atkus", cfg.levelCtrlAttackStepUs, 128000);
      // Gate, clock divider fields and widening depth
      wr(OFS_GATE, 9'h00D);
      check("gate", {cfg.gateOn, cfg.gateThreshold}, 13);
      wr(OFS_PLL_INT, 9'h016);
      check("halve", cfg.pllInputHalve, 1);
      check("pllint", cfg.pllIntegerRatio, 6);
      wr(OFS_PLL_INT, 9'h00C);
      check("pllint", {cfg.pllInputHalve, cfg.pllIntegerRatio}, 12);
      wr(OFS_PLL_FRAC_HIGH, 9'h02A);
      wr(OFS_PLL_FRAC_MID, 9'h155);
      wr(OFS_PLL_FRAC_LOW, 9'h0AB);
      check("frac", cfg.pllFractionRatio, {6'h2A, 9'h155, 9'h0AB});
      wr(OFS_WIDEN, 9'h00F);
      check("depth", {cfg.stereoWidenOn, cfg.stereoWidenDepth}, 31);
      wr(OFS_WIDEN, 9'h000);
      check("depth", {cfg.stereoWidenOn, cfg.stereoWidenDepth}, 0);
      // Notch: pending writes, then one commit takes all
      wr(OFS_NOTCH_A0_HIGH, 9'h0FF);
      rdChk(OFS_NOTCH_A0_HIGH, 9'h000);
      wr(OFS_NOTCH_A0_LOW, 9'h055);
      wr(OFS_NOTCH_A1_HIGH, 9'h02A);
      check("non", cfg.notchOn, 0);
      wr(OFS_NOTCH_A1_LOW, 9'h111);
      check("non", cfg.notchOn, 1);
      check("coef0", cfg.notchCoefZero, {7'h7F, 7'h55});
      check("coef1", cfg.notchCoefOne, {7'h2A, 7'h11});
      rdChk(OFS_NOTCH_A1_LOW, 9'h011);
      wr(OFS_NOTCH_A1_LOW, 9'h000);
      wr(OFS_NOTCH_A0_HIGH, 9'h100);
      check("non", cfg.notchOn, 0);
      check("coef1", cfg.notchCoefOne, {7'h2A, 7'h00});
      // Commit bit without its byte lane must not commit
      wbXfer(1'h1, OFS_NOTCH_A0_HIGH, 9'h180, 4'h1, d);
      check("non", cfg.notchOn, 0);
      // Second reset in mid-run restores defaults
      @(posedge clk_sys);
      reset <= 1'h1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'h0;
      @(posedge clk_sys);
      #1;
      rdChk(OFS_EQ_BAND5, 9'h02C);
      rdChk(OFS_NOTCH_A0_HIGH, 9'h000);
      check("corner", cfg.bandFiveCornerSel, 1);
      printVerdict();
   end
endmodule : dsp_config_registers_tb
